// [core/dac_serial_load.v]
`include "dac_load_defs.vh"
// ============================================================
// serial load control for a dual 14-bit converter
module dac_serial_load #(
  parameter FRAME_W = `FRAME_BITS,
  parameter DATA_W = `DATA_BITS
) (
  input wire clock,
  input wire srst,
  input wire select_n,
  input wire link_clk,
  input wire serial_in,
  input wire output_load_strobe_n,
  input wire reset_select_n,
  input wire preset_mid,
  output reg [DATA_W-1:0] input_a,
  output reg [DATA_W-1:0] input_b,
  output reg [DATA_W-1:0] code_a,
  output reg [DATA_W-1:0] code_b
);
  // ============================================================
  // pin synchronisers
  wire [4:0] pins_s;
  sync2 #(
    .WIDTH(5)
  ) u_sync (
    .clock(clock),
    .srst(srst),
    .d({select_n, link_clk, serial_in, output_load_strobe_n,
        reset_select_n}),
    .q(pins_s)
  );
  wire sel_s = pins_s[4];
  wire clk_s = pins_s[3];
  wire din_s = pins_s[2];
  wire strobe_s = pins_s[1];
  wire rst_s = pins_s[0];

  // preset level also passes two flops
  reg mid_m;
  reg mid_s;
  always @(posedge clock) begin
    if (srst) begin
      mid_m <= 1'b0;
      mid_s <= 1'b0;
    end else begin
      mid_m <= preset_mid;
      mid_s <= mid_m;
    end
  end

  // ============================================================
  // address decode, used for both channels
  function [1:0] decode_addr;
    input hi;
    input lo;
    begin
      decode_addr = {hi, lo}; // bit0 channel a, bit1 channel b RL7
    end
  endfunction

  // ============================================================
  // edge detection on synchronised pins
  reg clk_d;
  reg sel_d;
  reg [FRAME_W-1:0] shift_reg;
  wire clk_rise = clk_s & ~clk_d;
  wire sel_rise = sel_s & ~sel_d;
  // data passes the same two flops as the link clock, so it lines up with the edge
  always @(posedge clock) begin
    if (srst) begin
      clk_d <= 1'b0;
      sel_d <= 1'b1;
      shift_reg <= {FRAME_W{1'b0}};
    end else begin
      clk_d <= clk_s;
      sel_d <= sel_s;
      if (!sel_s && clk_rise)
        shift_reg <= {shift_reg[FRAME_W-2:0], din_s}; // RL1 RL6
    end
  end

  // ============================================================
  // input and output register stages
  wire [1:0] hit = decode_addr(shift_reg[`ADDR_HI_POS],
                               shift_reg[`ADDR_LO_POS]);
  wire [DATA_W-1:0] word = shift_reg[DATA_W-1:0];
  wire [DATA_W-1:0] preset = mid_s ? `MID_CODE : `ZERO_CODE;
  wire load_ok = sel_rise && !clk_s && rst_s;
  reg [DATA_W-1:0] next_a;
  reg [DATA_W-1:0] next_b;

  // next input values; extra bits beyond the frame fall off the top
  always @* begin
    next_a = input_a;
    next_b = input_b;
    if (load_ok && hit[0])
      next_a = word; // RL2 RL7
    if (load_ok && hit[1])
      next_b = word; // RL2 RL7
  end

  // srst stands in for power-on; the reset pin wins over everything but srst
  always @(posedge clock) begin
    if (srst) begin
      input_a <= `POWERON_CODE; // RL5
      input_b <= `POWERON_CODE;
      code_a <= `POWERON_CODE;
      code_b <= `POWERON_CODE;
    end else if (!rst_s) begin
      input_a <= preset; // RL3 RL4
      input_b <= preset;
      code_a <= preset;
      code_b <= preset;
    end else begin
      input_a <= next_a;
      input_b <= next_b;
      if (!strobe_s) begin
        code_a <= next_a; // RL8
        code_b <= next_b;
      end
      // strobe high: outputs held, both move together on next low RL9
    end
  end
endmodule

// [core/sync2.v]
// ============================================================
// two-stage synchroniser for pin levels
module sync2 #(
  parameter WIDTH = 1
) (
  input wire clock,
  input wire srst,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta;

  // first stage read only by the second
  always @(posedge clock) begin
    if (srst) begin
      meta <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// [inc/dac_load_defs.vh]
`ifndef DAC_LOAD_DEFS_VH
`define DAC_LOAD_DEFS_VH
// Behaviour
// RL1: shift serial_in on each link clock rise while select low; else hold.
// RL2: select rising with clock low, reset idle, loads addressed input registers.
// RL3: reset low with preset level low forces all registers to zero.
// RL4: reset low with preset level high forces all registers to midscale.
// RL5: power-on clears every input and output register to zero.
// RL6: frame is 16 bits msb first, two address then 14 data.
// RL7: address 00 none, 01 channel a, 10 channel b, 11 both.
// RL8: load strobe low makes output registers follow input registers.
// RL9: load strobe high, and its rise, holds the output registers.
// ============================================================
// frame layout
`define FRAME_BITS 16
`define DATA_BITS 14
`define ADDR_HI_POS 15
`define ADDR_LO_POS 14
// ============================================================
// preset values
`define ZERO_CODE 14'h0000
`define MID_CODE 14'h2000
`define POWERON_CODE 14'h0000
`endif

// [verif/dac_load_props_props.sv]
// ====
// pin checker; pins pass two flops, so effects lag a few clocks
module dac_load_props (
  input logic clock,
  input logic srst,
  input logic select_n,
  input logic output_load_strobe_n,
  input logic reset_select_n,
  input logic preset_mid,
  input logic [13:0] input_a,
  input logic [13:0] code_a
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence sel_up; $rose(select_n) && reset_select_n; endsequence
  sequence sb_low; !output_load_strobe_n [*5]; endsequence
  // strobe and reset pin both idle long enough to pass the synchronisers
  sequence hold_pins;
    (output_load_strobe_n && reset_select_n) [*5];
  endsequence
  sequence zero_reset; (!reset_select_n && !preset_mid) [*5]; endsequence
  a_por_clear: assert property ($fell(srst) |-> !input_a && !code_a)
    else $error("not cleared");
  a_preset_mid: assert property ((!reset_select_n && preset_mid) [*5]
    |-> code_a == 14'h2000) else $error("not midscale");
  a_load_late: assert property (sel_up |=> $stable(input_a) [*2])
    else $error("early load");
  a_out_follow: assert property (sb_low |-> code_a == input_a)
    else $error("not transparent");
  a_preset_zero: assert property (zero_reset |-> !code_a && !input_a)
    else $error("not zero");
  a_strobe_hold: assert property (hold_pins |=> $stable(code_a))
    else $error("output moved with strobe high");
endmodule
bind dac_serial_load dac_load_props props (.*);

// [verif/serial_host.sv]
// ====
// host end of the link; link clock idles low between frames
module serial_host (
  input logic clock,
  output logic select_n = 1,
  output logic link_clk = 0,
  output logic serial_in = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  // one extra leading bit, which the device must drop
  task automatic send(input logic [16:0] f);
    select_n <= 0;
    for (int i = 16; i >= 0; i--) begin
      serial_in <= f[i];
      repeat (4) @(posedge clock);
      link_clk <= 1;
      repeat (4) @(posedge clock);
      link_clk <= 0;
    end
    serial_in <= !f[0];
    repeat (4) @(posedge clock);
    select_n <= 1;
    repeat (8) @(posedge clock);
  endtask
endmodule

// [verif/testbench.sv]
// ====
// bench: host frames, strobe and preset pins against a model
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, srst = 1, output_load_strobe_n = 1;
  logic reset_select_n = 1, preset_mid = 0;
  logic [13:0] input_a, input_b, code_a, code_b;
  logic [13:0] ma = 0, mb = 0, ca = 0, cb = 0;
  logic [31:0] r = 32'h1e8c;
  int err_count = 0, check_count = 0;
  wire select_n, link_clk, serial_in;
  always #12.5 clock = ~clock; // 40 mhz
  serial_host host (.*);
  dac_serial_load dut (.*);
  task chk;
    check_count++;
    if ({input_a, input_b, code_a, code_b} !== {ma, mb, ca, cb}) begin
      err_count++;
      $display("mismatch %0t registers", $time);
    end
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // hang guard, about nine times the run
  initial begin
    #300000 err_count++;
    give_verdict;
  end
  // every address code, then both preset levels
  initial begin
    repeat (5) @(posedge clock);
    srst <= 0;
    repeat (4) @(posedge clock);
    chk;
    for (int k = 0; k < 9; k++) begin
      r = xs(r);
      output_load_strobe_n <= k != 7;
      host.send({r[16], k[1:0], r[13:0]});
      if (k[0]) ma = r[13:0];
      if (k[1]) mb = r[13:0];
      if (k == 7) {ca, cb} = {ma, mb};
      chk;
    end
    for (int p = 0; p < 2; p++) begin
      preset_mid <= p[0];
      reset_select_n <= 0;
      repeat (6) @(posedge clock);
      {ma, mb, ca, cb} = {4{p[0], 13'h0000}};
      chk;
      reset_select_n <= 1;
      repeat (6) @(posedge clock);
    end
    give_verdict;
  end
endmodule
